/* File: bench/dcl_ctrl_model.sv */
// Behavioural controller that drives the configuration write pins.
// Assumes a free-running clock; calls come from the bench through write_bank and set_speed.
`timescale 1ns/10ps
module dcl_ctrl_model
    import dcl_pkg::*;
(
    // Clock
    input  wire logic  clock,
    // Configuration pins
    output logic       config_write_strobe_n,
    output logic [2:0] config_addr,
    output dcl_bank_t  config_data,
    output logic [1:0] speed_range_select
);
    dcl_bank_t shadow [0:7];

    initial begin
        config_write_strobe_n = 1'b1;
        config_addr           = 3'h0;
        config_data           = 7'h00;
        speed_range_select    = 2'b11;
    end

    // Misuse lets a scenario break the controller's own obligations
    task automatic write_bank(input logic [2:0] a, input dcl_bank_t d, input bit misuse);
        dcl_bank_t w;
        w = d;
        if (!misuse) begin
            if (a == 3'h0 || a == 3'h5) w = (d & 7'h19) | 7'h40;
            if ((a == 3'h1 || a == 3'h6) && !speed_range_select[a[2]]) w[0] = 1'b0;
            if ((a == 3'h2 || a == 3'h7) && (w[6] == w[4])) w[4] = ~w[6];
        end
        shadow[a] = w;
        @(posedge clock);
        config_addr <= a;
        config_data <= w;
        @(posedge clock);
        config_write_strobe_n <= 1'b0;
        repeat (4) @(posedge clock);
        config_write_strobe_n <= 1'b1;
        repeat (3) @(posedge clock);
        // Released bus shows the inverse, never a stale copy
        config_addr <= ~a;
        config_data <= ~w;
        repeat (2) @(posedge clock);
    endtask

    task automatic set_speed(input logic [1:0] s);
        @(posedge clock);
        speed_range_select <= s;
        repeat (4) @(posedge clock);
    endtask
endmodule

/* File: bench/testbench.sv */
// Self-checking bench for the configuration latches.
// Assumes the controller model drives every write pin of the design.
`timescale 1ns/10ps
module testbench
    import dcl_pkg::*;
;
    logic             clock;
    logic             rst_b;
    logic             config_write_strobe_n;
    logic [2:0]       config_addr;
    dcl_bank_t        config_data;
    logic [1:0]       speed_range_select;
    logic [1:0]       recovered_clock_rate_sel;
    logic [1:0][1:0]  primary_detect_threshold_sel;
    logic [1:0][1:0]  secondary_detect_threshold_sel;
    logic [1:0]       training_clock_multiplier_sel;
    logic [1:0]       rx_channel_power_on;
    logic [1:0][1:0]  reception_mode_sel;
    logic [1:0]       primary_retimed_out_enable;
    logic [1:0]       secondary_retimed_out_enable;
    logic [1:0]       reclock_power_on;
    logic [1:0]       self_test_enable;
    logic [1:0]       video_rx_enable;
    logic [1:0]       reception_mode_invalid;
    logic [1:0]       reserved_rate_combo;
    dcl_bank_t        eb [0:7];
    int               err_total = 0;
    int               comparisons = 0;

    dcl_ctrl_model dcl_ctrl_model_inst (
        .clock(clock), .config_write_strobe_n(config_write_strobe_n),
        .config_addr(config_addr), .config_data(config_data),
        .speed_range_select(speed_range_select));

    dcl_config_latches #(.NUM_CH(2)) dcl_config_latches_inst (
        .clock(clock), .rst_b(rst_b), .config_write_strobe_n(config_write_strobe_n),
        .config_addr(config_addr), .config_data(config_data),
        .speed_range_select(speed_range_select),
        .recovered_clock_rate_sel(recovered_clock_rate_sel),
        .primary_detect_threshold_sel(primary_detect_threshold_sel),
        .secondary_detect_threshold_sel(secondary_detect_threshold_sel),
        .training_clock_multiplier_sel(training_clock_multiplier_sel),
        .rx_channel_power_on(rx_channel_power_on), .reception_mode_sel(reception_mode_sel),
        .primary_retimed_out_enable(primary_retimed_out_enable),
        .secondary_retimed_out_enable(secondary_retimed_out_enable),
        .reclock_power_on(reclock_power_on), .self_test_enable(self_test_enable),
        .video_rx_enable(video_rx_enable), .reception_mode_invalid(reception_mode_invalid),
        .reserved_rate_combo(reserved_rate_combo));

    task automatic close_out();
        if (err_total == 0 && comparisons > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic reset_exp();
        eb[0] = 7'h41;
        eb[5] = 7'h41;
        eb[1] = 7'h50;
        eb[6] = 7'h50;
        eb[2] = 7'h50;
        eb[7] = 7'h50;
    endtask

    // Fields and derived controls worked out from the expected bank words
    task automatic verify();
        logic [1:0] md;
        logic [9:0] ed;
        for (int c = 0; c < 2; c++) begin
            md = {eb[c ? 7 : 2][6], eb[c ? 7 : 2][4]};
            ed[8 + c] = eb[c ? 7 : 2][1] | eb[c ? 7 : 2][2];
            ed[6 + c] = (md == 2'b10);
            ed[4 + c] = (md == 2'b01);
            ed[2 + c] = (md == 2'b00) || (md == 2'b11);
            ed[c]     = eb[c ? 6 : 1][0] & ~speed_range_select[c];
        end
        check({recovered_clock_rate_sel, primary_detect_threshold_sel,
               secondary_detect_threshold_sel, training_clock_multiplier_sel,
               rx_channel_power_on, reception_mode_sel, primary_retimed_out_enable,
               secondary_retimed_out_enable},
              {eb[5][0], eb[0][0], eb[6][4:3], eb[1][4:3], eb[6][6:5], eb[1][6:5],
               eb[6][0], eb[1][0], eb[7][5], eb[2][5], eb[7][6], eb[7][4], eb[2][6],
               eb[2][4], eb[7][1], eb[2][1], eb[7][2], eb[2][2]});
        check({reclock_power_on, self_test_enable, video_rx_enable,
               reception_mode_invalid, reserved_rate_combo}, ed);
    endtask

    task automatic wr(input logic [2:0] a, input dcl_bank_t d, input bit m);
        dcl_ctrl_model_inst.write_bank(a, d, m);
        if (a != 3'h3 && a != 3'h4) eb[a] = dcl_ctrl_model_inst.shadow[a];
        verify();
    endtask

    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    initial begin
        #40000;
        err_total++;
        close_out();
    end

    initial begin
        rst_b = 1'b0;
        reset_exp();
        repeat (6) @(posedge clock);
        rst_b <= 1'b1;
        @(posedge clock);
        verify();
        wr(3'h0, 7'h40, 1'b0);
        wr(3'h5, 7'h01, 1'b0);
        for (int i = 0; i < 4; i++) begin
            wr(3'h1, {i[1:0], ~i[1:0], 3'b001}, 1'b0);
            wr(3'h6, {~i[1:0], i[1:0], 3'b000}, 1'b0);
        end
        wr(3'h2, 7'h32, 1'b0);
        wr(3'h7, 7'h44, 1'b0);
        wr(3'h2, 7'h30, 1'b0);
        wr(3'h3, 7'h7f, 1'b0);
        wr(3'h4, 7'h2a, 1'b0);
        dcl_ctrl_model_inst.set_speed(2'b10);
        wr(3'h1, 7'h51, 1'b0);
        wr(3'h1, 7'h51, 1'b1);
        wr(3'h7, 7'h00, 1'b1);
        wr(3'h2, 7'h06, 1'b1);
        dcl_ctrl_model_inst.set_speed(2'b01);
        wr(3'h6, 7'h19, 1'b1);
        @(posedge clock);
        rst_b <= 1'b0;
        repeat (2) @(posedge clock);
        reset_exp();
        verify();
        rst_b <= 1'b1;
        repeat (2) @(posedge clock);
        verify();
        close_out();
    end
endmodule

/* File: core/dcl_config_latches.sv */
// Configuration latch file of a dual-channel reclocking deserializer.
// Assumes write strobe, address, data and speed pins are asynchronous
// to clock and held stable by the controller for at least three cycles.
//
// What this block and its controller do
// R1: Six 7-bit write-only latch banks, never read.
// R2: Strobe low captures data into addressed bank.
// R3: Channels configured independently of each other.
// R4: Addresses 0 to 2 configure channel A.
// R5: Banks 0,1,5,6 static; 2,7 dynamic.
// R6: Addresses 3 and 4 reserved, no channel effect.
// R7: Controller writes fixed bits with prescribed values.
// R8: Clock rate select resets to 1, half rate.
// R9: Clock rate select 0 gives full rate.
// R10: Primary detect threshold resets to 10.
// R11: Secondary detect threshold same encoding and reset.
// R12: Training multiplier resets 0; 1 doubles clock.
// R13: Controller avoids multiplier 1 with speed low.
// R14: Receive power resets 0, off; 1 enables.
// R15: Reception mode resets 11; 01 video, 10 selftest.
// R16: Controller writes mode 01 or 10 before use.
// R17: Primary retimed output enable resets 0.
// R18: Secondary retimed output enable resets 0.
// R19: Both drivers off powers down reclocking logic.
// R20: Reset disables drivers, restores all latches.
// R21: Controller resets, writes static, then dynamic banks.
// R22: Controller shadows banks, rewrites whole words.
`timescale 1ns/10ps
`include "dcl_cfg.svh"
module dcl_config_latches
    import dcl_pkg::*;
#(
    parameter int NUM_CH = `DCL_NUM_CH
) (
    // Clock and reset
    input  wire logic              clock,
    input  wire logic              rst_b,
    // Configuration write port pins
    input  wire logic              config_write_strobe_n,
    input  wire logic [2:0]        config_addr,
    input  wire dcl_bank_t         config_data,
    // Speed range pins, one per channel
    input  wire logic [NUM_CH-1:0] speed_range_select,
    // Static settings, one entry per channel
    output logic [NUM_CH-1:0]      recovered_clock_rate_sel,
    output logic [NUM_CH-1:0][1:0] primary_detect_threshold_sel,
    output logic [NUM_CH-1:0][1:0] secondary_detect_threshold_sel,
    output logic [NUM_CH-1:0]      training_clock_multiplier_sel,
    // Dynamic settings, one entry per channel
    output logic [NUM_CH-1:0]      rx_channel_power_on,
    output logic [NUM_CH-1:0][1:0] reception_mode_sel,
    output logic [NUM_CH-1:0]      primary_retimed_out_enable,
    output logic [NUM_CH-1:0]      secondary_retimed_out_enable,
    // Derived controls and status, one entry per channel
    output logic [NUM_CH-1:0]      reclock_power_on,
    output logic [NUM_CH-1:0]      self_test_enable,
    output logic [NUM_CH-1:0]      video_rx_enable,
    output logic [NUM_CH-1:0]      reception_mode_invalid,
    output logic [NUM_CH-1:0]      reserved_rate_combo
);

    // Bank index to address: channel base plus position in channel
    function automatic logic [2:0] bank_addr(input int idx);
        logic [2:0] base;
        base = (idx >= `DCL_BANKS_PER_CH) ? `DCL_ADDR_B_S0 : `DCL_ADDR_A_S0;
        return base + 3'(idx % `DCL_BANKS_PER_CH);
    endfunction

    // Bank index to its reset word
    function automatic dcl_bank_t bank_reset(input int idx);
        dcl_bank_t val;
        case (idx % `DCL_BANKS_PER_CH)
            0:       val = `DCL_RST_S0;
            1:       val = `DCL_RST_S1;
            default: val = `DCL_RST_DYN;
        endcase
        return val;
    endfunction

    // Pin synchronisers
    logic                strobe_s1_r;
    logic                strobe_s2_r;
    logic [2:0]          addr_s1_r;
    logic [2:0]          addr_s2_r;
    dcl_bank_t           data_s1_r;
    dcl_bank_t           data_s2_r;
    logic [NUM_CH-1:0]   speed_s1_r;
    logic [NUM_CH-1:0]   speed_s2_r;

    // Bank storage
    logic [`DCL_NUM_BANKS-1:0] bank_we;
    dcl_bank_t                 bank_q [`DCL_NUM_BANKS];
    logic                      wr_active;
    logic                      wr_test_addr;

    // Derived flops and their next values
    logic [NUM_CH-1:0]   reclock_pwr_r;
    logic [NUM_CH-1:0]   self_test_r;
    logic [NUM_CH-1:0]   video_r;
    logic [NUM_CH-1:0]   mode_bad_r;
    logic [NUM_CH-1:0]   rsvd_combo_r;
    logic [NUM_CH-1:0]   reclock_pwr_nxt;
    logic [NUM_CH-1:0]   self_test_nxt;
    logic [NUM_CH-1:0]   video_nxt;
    logic [NUM_CH-1:0]   mode_bad_nxt;
    logic [NUM_CH-1:0]   rsvd_combo_nxt;

    // Pins are asynchronous; two flops before any use
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            strobe_s1_r <= 1'b1;
            strobe_s2_r <= 1'b1;
            addr_s1_r   <= 3'h0;
            addr_s2_r   <= 3'h0;
            data_s1_r   <= 7'h00;
            data_s2_r   <= 7'h00;
            speed_s1_r  <= '0;
            speed_s2_r  <= '0;
        end else begin
            strobe_s1_r <= config_write_strobe_n;
            strobe_s2_r <= strobe_s1_r;
            addr_s1_r   <= config_addr;
            addr_s2_r   <= addr_s1_r;
            data_s1_r   <= config_data;
            data_s2_r   <= data_s1_r;
            speed_s1_r  <= speed_range_select;
            speed_s2_r  <= speed_s1_r;
        end
    end

    // Level-sensitive capture: every cycle the strobe is low writes
    assign wr_active    = !strobe_s2_r;                                     // [R2]
    // Test addresses decode to no bank
    assign wr_test_addr = wr_active && (addr_s2_r == `DCL_ADDR_TEST0 ||
                                        addr_s2_r == `DCL_ADDR_TEST1);      // [R6]

    // Six banks; index 0..2 channel A, 3..5 channel B
    for (genvar i = 0; i < `DCL_NUM_BANKS; i++) begin : g_bank
        assign bank_we[i] = wr_active && (addr_s2_r == bank_addr(i));     // [R2] [R4] [R5]

        dcl_latch_bank #(
            .RESET_VAL (bank_reset(i))                                      // [R20]
        ) u_bank (
            .clock   (clock),
            .rst_b   (rst_b),
            .wr_en   (bank_we[i]),                                          // [R3]
            .wr_data (data_s2_r),
            .bank_q  (bank_q[i])
        );
    end

    // Field slices; no read path exists for any bank [R1]
    for (genvar c = 0; c < NUM_CH; c++) begin : g_chan
        localparam int S0  = c * `DCL_BANKS_PER_CH;
        localparam int S1  = S0 + 1;
        localparam int DYN = S0 + 2;

        // 1 half rate, 0 full rate
        assign recovered_clock_rate_sel[c] = bank_q[S0][`DCL_RATE_BIT];      // [R8] [R9]
        assign primary_detect_threshold_sel[c] =
            bank_q[S1][`DCL_SD1_LSB +: 2];                                   // [R10]
        assign secondary_detect_threshold_sel[c] =
            bank_q[S1][`DCL_SD2_LSB +: 2];                                   // [R11]
        assign training_clock_multiplier_sel[c] = bank_q[S1][`DCL_TRG_BIT];  // [R12]
        assign rx_channel_power_on[c] = bank_q[DYN][`DCL_PWR_BIT];           // [R14]
        assign reception_mode_sel[c] = {bank_q[DYN][`DCL_MODE_HI_BIT],
                                        bank_q[DYN][`DCL_MODE_LO_BIT]};      // [R15]
        assign primary_retimed_out_enable[c] = bank_q[DYN][`DCL_ROE1_BIT];   // [R17]
        assign secondary_retimed_out_enable[c] = bank_q[DYN][`DCL_ROE2_BIT]; // [R18]

        // Reclocker stays powered while either driver is on
        assign reclock_pwr_nxt[c] = primary_retimed_out_enable[c] |
                                    secondary_retimed_out_enable[c];         // [R19]
        assign self_test_nxt[c]   = reception_mode_sel[c] == DCL_MODE_SELFTST;
        assign video_nxt[c]       = reception_mode_sel[c] == DCL_MODE_VIDEO;
        assign mode_bad_nxt[c]    = !(self_test_nxt[c] || video_nxt[c]);
        // Flags the reserved multiplier and speed pairing
        assign rsvd_combo_nxt[c]  = training_clock_multiplier_sel[c] &
                                    !speed_s2_r[c];
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            reclock_pwr_r <= '0;                                            // [R20]
            self_test_r   <= '0;
            video_r       <= '0;
            mode_bad_r    <= '1;
            rsvd_combo_r  <= '0;
        end else begin
            reclock_pwr_r <= reclock_pwr_nxt;                               // [R19]
            self_test_r   <= self_test_nxt;                                 // [R15]
            video_r       <= video_nxt;                                     // [R15]
            mode_bad_r    <= mode_bad_nxt;
            rsvd_combo_r  <= rsvd_combo_nxt;
        end
    end

    assign reclock_power_on       = reclock_pwr_r;
    assign self_test_enable       = self_test_r;
    assign video_rx_enable        = video_r;
    assign reception_mode_invalid = mode_bad_r;
    assign reserved_rate_combo    = rsvd_combo_r;

    // Checks
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_b);

    // Marks the first edge after reset release
    logic after_rst_r;
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            after_rst_r <= 1'b1;
        end else begin
            after_rst_r <= 1'b0;
        end
    end

    // Pin write held for three cycles with stable address and data
    sequence pin_write_held(logic [2:0] a);
        (!config_write_strobe_n && config_addr == a && $stable(config_data)
         && $stable(config_addr))[*3];
    endsequence

    // Synchronised write seen at the capture stage
    sequence sync_write(logic [2:0] a);
        wr_active && addr_s2_r == a;
    endsequence

    bank_capture_a: assert property ( // [R2]
        sync_write(`DCL_ADDR_B_DYN) |=> bank_q[5] == $past(data_s2_r))
        else $error("dynamic bank B did not capture written data");

    pin_to_bank_a: assert property ( // [R2]
        pin_write_held(`DCL_ADDR_A_DYN) |=> bank_q[2] == $past(config_data))
        else $error("pin write did not reach dynamic bank A in three cycles");

    banks_hold_a: assert property ( // [R1]
        !wr_active |=> $stable(bank_q[0]) && $stable(bank_q[1]) &&
                       $stable(bank_q[2]) && $stable(bank_q[3]) &&
                       $stable(bank_q[4]) && $stable(bank_q[5]))
        else $error("bank changed without a write");

    chan_isolation_a: assert property ( // [R3]
        wr_active && addr_s2_r <= `DCL_ADDR_A_DYN |=>
            $stable(bank_q[3]) && $stable(bank_q[4]) && $stable(bank_q[5]))
        else $error("channel A write disturbed channel B");

    test_addr_ignored_a: assert property ( // [R6]
        wr_test_addr |=> $stable(bank_q[0]) && $stable(bank_q[1]) &&
                         $stable(bank_q[2]) && $stable(bank_q[3]) &&
                         $stable(bank_q[4]) && $stable(bank_q[5]))
        else $error("test address write changed a channel bank");

    reset_values_a: assert property ( // [R20]
        after_rst_r |-> recovered_clock_rate_sel == '1 &&
            primary_detect_threshold_sel == {NUM_CH{DCL_SD_MID}} &&
            secondary_detect_threshold_sel == {NUM_CH{DCL_SD_MID}} &&
            training_clock_multiplier_sel == '0 &&
            rx_channel_power_on == '0 &&
            reception_mode_sel == {NUM_CH{DCL_MODE_BAD3}} &&
            primary_retimed_out_enable == '0 &&
            secondary_retimed_out_enable == '0 && reclock_power_on == '0 &&
            self_test_enable == '0 && video_rx_enable == '0 &&
            reception_mode_invalid == '1 && reserved_rate_combo == '0)
        else $error("latches not at initial values after reset");

    reclock_off_a: assert property ( // [R19]
        !primary_retimed_out_enable[1] && !secondary_retimed_out_enable[1]
        |=> !reclock_power_on[1])
        else $error("reclocker B powered with both drivers off");

    reclock_on_a: assert property ( // [R19]
        $rose(secondary_retimed_out_enable[0]) |=> reclock_power_on[0])
        else $error("reclocker A not powered after driver enable");

    mode_decode_a: assert property ( // [R15]
        reception_mode_sel[0] == DCL_MODE_VIDEO ##1
        reception_mode_sel[0] == DCL_MODE_VIDEO
        |-> video_rx_enable[0] && !self_test_enable[0] &&
            !reception_mode_invalid[0])
        else $error("video mode not decoded on channel A");

    rsvd_flag_a: assert property ( // [R13]
        training_clock_multiplier_sel[1] && !speed_s2_r[1] |=>
            reserved_rate_combo[1])
        else $error("reserved multiplier pairing not flagged");

    reclock_prim_a: assert property ( // [R19]
        primary_retimed_out_enable[0] |=> reclock_power_on[0])
        else $error("reclocker A not powered with primary driver on");

    rsvd_clear_a: assert property ( // [R13]
        !training_clock_multiplier_sel[0] |=> !reserved_rate_combo[0])
        else $error("reserved pairing flagged with multiplier off");

    // Channel B write seen at the capture stage
    sequence chan_b_write;
        wr_active && addr_s2_r >= `DCL_ADDR_B_S0;
    endsequence

    chan_a_kept_a: assert property ( // [R3]
        chan_b_write |=> $stable(bank_q[0]) && $stable(bank_q[1]) && $stable(bank_q[2]))
        else $error("channel B write disturbed channel A");

    // Channel B mode held over two edges
    sequence b_mode_held(logic [1:0] m);
        reception_mode_sel[1] == m ##1 reception_mode_sel[1] == m;
    endsequence

    selftest_decode_a: assert property ( // [R15]
        b_mode_held(DCL_MODE_SELFTST) |-> self_test_enable[1] &&
            !video_rx_enable[1] && !reception_mode_invalid[1])
        else $error("self-test mode not decoded on channel B");

    mode_invalid_a: assert property ( // [R15]
        b_mode_held(DCL_MODE_BAD0) |-> reception_mode_invalid[1] &&
            !self_test_enable[1] && !video_rx_enable[1])
        else $error("invalid mode not flagged on channel B");

    rate_write_a: assert property ( // [R8] [R9]
        sync_write(`DCL_ADDR_A_S0) |=>
            recovered_clock_rate_sel[0] == $past(data_s2_r[`DCL_RATE_BIT]))
        else $error("rate select A did not follow its bank write");

    thresh_write_a: assert property ( // [R10] [R11]
        sync_write(`DCL_ADDR_A_S1) |=>
            primary_detect_threshold_sel[0] == $past(data_s2_r[`DCL_SD1_LSB +: 2]) &&
            secondary_detect_threshold_sel[0] == $past(data_s2_r[`DCL_SD2_LSB +: 2]))
        else $error("detect thresholds A did not follow their bank write");

    train_write_a: assert property ( // [R12]
        sync_write(`DCL_ADDR_B_S1) |=>
            training_clock_multiplier_sel[1] == $past(data_s2_r[`DCL_TRG_BIT]))
        else $error("multiplier select B did not follow its bank write");

    power_write_a: assert property ( // [R14]
        sync_write(`DCL_ADDR_B_DYN) |=>
            rx_channel_power_on[1] == $past(data_s2_r[`DCL_PWR_BIT]))
        else $error("power enable B did not follow its bank write");

    mode_write_a: assert property ( // [R15]
        sync_write(`DCL_ADDR_B_DYN) |=>
            reception_mode_sel[1] == {$past(data_s2_r[`DCL_MODE_HI_BIT]),
                                      $past(data_s2_r[`DCL_MODE_LO_BIT])})
        else $error("reception mode B did not follow its bank write");

    roe_write_a: assert property ( // [R17] [R18]
        sync_write(`DCL_ADDR_A_DYN) |=>
            primary_retimed_out_enable[0] == $past(data_s2_r[`DCL_ROE1_BIT]) &&
            secondary_retimed_out_enable[0] == $past(data_s2_r[`DCL_ROE2_BIT]))
        else $error("driver enables A did not follow their bank write");

endmodule

/* File: core/dcl_latch_bank.sv */
// One 7-bit write-only configuration latch bank.
// Assumes write enable and data come from the same clock domain.
`timescale 1ns/10ps
module dcl_latch_bank
    import dcl_pkg::*;
#(
    parameter dcl_bank_t RESET_VAL = 7'h00
) (
    // Clock and reset
    input  wire logic      clock,
    input  wire logic      rst_b,
    // Write side
    input  wire logic      wr_en,
    input  wire dcl_bank_t wr_data,
    // Stored word
    output dcl_bank_t      bank_q
);
    dcl_bank_t bank_r;
    dcl_bank_t bank_nxt;

    assign bank_nxt = wr_en ? wr_data : bank_r;
    assign bank_q   = bank_r;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            bank_r <= RESET_VAL;
        end else begin
            bank_r <= bank_nxt;
        end
    end
endmodule

/* File: include/dcl_cfg.svh */
// Constants for the dual-channel configuration latches.
// Assumes inclusion by bare name from include/.
`ifndef DCL_CFG_SVH
`define DCL_CFG_SVH

// Bus geometry
`define DCL_ADDR_W        3
`define DCL_DATA_W        7
`define DCL_NUM_CH        2
`define DCL_BANKS_PER_CH  3
`define DCL_NUM_BANKS     6

// Bank addresses
`define DCL_ADDR_A_S0     3'h0
`define DCL_ADDR_A_S1     3'h1
`define DCL_ADDR_A_DYN    3'h2
`define DCL_ADDR_TEST0    3'h3
`define DCL_ADDR_TEST1    3'h4
`define DCL_ADDR_B_S0     3'h5
`define DCL_ADDR_B_S1     3'h6
`define DCL_ADDR_B_DYN    3'h7

// Field positions, static bank 0
`define DCL_RATE_BIT      0
// Field positions, static bank 1
`define DCL_TRG_BIT       0
`define DCL_SD1_LSB       3
`define DCL_SD2_LSB       5
// Field positions, dynamic bank
`define DCL_ROE1_BIT      1
`define DCL_ROE2_BIT      2
`define DCL_MODE_LO_BIT   4
`define DCL_PWR_BIT       5
`define DCL_MODE_HI_BIT   6

// Reset words (fixed bits set, don't-care bits zero)
`define DCL_RST_S0        7'h41
`define DCL_RST_S1        7'h50
`define DCL_RST_DYN       7'h50

`endif

/* File: include/dcl_pkg.sv */
// Types shared by the configuration latch design.
// Assumes dcl_cfg.svh is on the include path.
package dcl_pkg;
    typedef logic [6:0] dcl_bank_t;

    typedef enum logic [1:0] {
        DCL_MODE_BAD0    = 2'h0,
        DCL_MODE_VIDEO   = 2'h1,
        DCL_MODE_SELFTST = 2'h2,
        DCL_MODE_BAD3    = 2'h3
    } dcl_rx_mode_t;

    typedef enum logic [1:0] {
        DCL_SD_OFF  = 2'h0,
        DCL_SD_LOW  = 2'h1,
        DCL_SD_MID  = 2'h2,
        DCL_SD_HIGH = 2'h3
    } dcl_sd_thresh_t;
endpackage
